/* File: src/gspe_map.svh */
// Constants for the status and poll enable block
`ifndef GSPE_MAP_SVH
`define GSPE_MAP_SVH

// Status byte bit positions
`define GSPE_STB_MAV_BIT      4
`define GSPE_STB_ESB_BIT      5
`define GSPE_STB_MSS_BIT      6

// Reset values
`define GSPE_SRE_RESET        8'hbf
`define GSPE_PRE_RESET        16'hffff

// Service request mask: bit 6 can never be stored
`define GSPE_SRE_WRITE_MASK   8'hbf

// Parallel poll mode codes
`define GSPE_PPM_NONE_S1      5'h00
`define GSPE_PPM_LAST_S1      5'h08
`define GSPE_PPM_LAST_S0      5'h10
`define GSPE_PPM_NONE_S0      5'h11

// Acknowledge characters
`define GSPE_ACK_OK           8'h30
`define GSPE_ACK_ERR          8'h3f

`endif

/* File: src/gspe_pkg.sv */
// Types for the status and poll enable block
package gspe_pkg;

  // Command strobes from the command parser
  typedef struct packed {
    logic        sre_write;
    logic [7:0]  sre_value;
    logic        pre_write;
    logic [16:0] pre_value;   // Bit 16 flags an out-of-range decimal
    logic        clear_status;
    logic        ppm_write;
    logic [4:0]  ppm_value;
  } gspe_cmd_type;

  // Parallel poll answer presented to the bus interface
  typedef struct packed {
    logic        respond;
    logic [2:0]  line;
    logic        sense;
  } gspe_poll_type;

endpackage : gspe_pkg

/* File: src/gspe_status_poll.sv */
// Service request and parallel poll enable logic with status byte summary
// ----------------------------------------------------------------------------
// Overview of operation
// - Service request enable query returns the 8-bit mask; bit 6 is never set.
// - Mask bit 5 set: event summary bit raises master summary and service request.
// - Clear status empties event registers and output buffer, and the summary bit unless an event sets it in the same cycle; no reply.
// - Individual status reads 1 when any status bit and its enable bit are set.
// - Parallel poll enable write carries a 16-bit mask 0 to 65535, stored as given.
// - Any enabled pair set makes the device answer a poll on the line/sense of modes 1-16.
// - Parallel poll enable mask comes out of reset as all ones.
// - Parallel poll enable write acknowledges with 0, or question mark on error.
// - A zero enable mask gives no parallel poll answer at all.
// - Mask 64 answers a poll only while master summary is set.
// - Status byte: 16 message waiting, 32 event summary, 64 service request.
// - Mode 0 none, 1-8 sense 1, 9-16 sense 0, 17 none with sense 0.
// ----------------------------------------------------------------------------
`include "gspe_map.svh"
`timescale 1ns/1ps
`default_nettype none

module gspe_status_poll (
  input  wire logic                  clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  clk_en_in,
  input  wire gspe_pkg::gspe_cmd_type cmd_in,
  input  wire logic                  event_set_in,
  input  wire logic                  msg_avail_in,
  input  wire logic [15:0]           other_status_in,
  output logic [7:0]                 sre_mask_out,
  output logic [15:0]                pre_mask_out,
  output logic [15:0]                status_byte_out,
  output logic                       ist_out,
  output logic                       srq_out,
  output gspe_pkg::gspe_poll_type    poll_out,
  output logic [4:0]                 ppm_out,
  output logic                       ack_valid_out,
  output logic [7:0]                 ack_char_out,
  output logic                       flush_out
);
  import gspe_pkg::*;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0]  service_request_enable_mask;
  logic [15:0] parallel_poll_enable_mask;
  logic [4:0]  parallel_poll_line_sense_setting;
  logic        event_summary;
  logic        ack_valid;
  logic [7:0]  ack_char;
  logic        flush;

  // --------------------------------------------------------------------------
  // Status byte assembly
  // --------------------------------------------------------------------------
  wire         mss;
  wire [15:0]  stb_low;
  wire [15:0]  status_byte;
  wire         pre_ok;
  wire         ist;
  wire         mode_has_line;

  // Status byte without MSS; MSS bit is excluded from the service summary
  assign stb_low = {other_status_in[15:7], 1'b0, event_summary, msg_avail_in, other_status_in[3:0]};
  assign mss = |(stb_low[7:0] & service_request_enable_mask);
  assign status_byte = stb_low | ({15'h0000, mss} << `GSPE_STB_MSS_BIT);
  // Combinational so a poll never sees a stale mask
  assign ist = |(status_byte & parallel_poll_enable_mask);
  assign pre_ok = ~cmd_in.pre_value[16];
  assign mode_has_line = (parallel_poll_line_sense_setting != `GSPE_PPM_NONE_S1) &&
                         (parallel_poll_line_sense_setting <= `GSPE_PPM_LAST_S0);

  // --------------------------------------------------------------------------
  // Mask and mode registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      service_request_enable_mask      <= `GSPE_SRE_RESET;
      parallel_poll_enable_mask        <= `GSPE_PRE_RESET;
      parallel_poll_line_sense_setting <= `GSPE_PPM_NONE_S1;
    end else if (clk_en_in) begin
      if (cmd_in.sre_write)
        service_request_enable_mask <= cmd_in.sre_value & `GSPE_SRE_WRITE_MASK;
      if (cmd_in.pre_write && pre_ok)
        parallel_poll_enable_mask <= cmd_in.pre_value[15:0];
      if (cmd_in.ppm_write && cmd_in.ppm_value <= `GSPE_PPM_NONE_S0)
        parallel_poll_line_sense_setting <= cmd_in.ppm_value;
    end
  end

  // --------------------------------------------------------------------------
  // Event summary: set wins over clear so an event is never lost
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      event_summary <= 1'b0;
    end else if (clk_en_in) begin
      if (event_set_in)
        event_summary <= 1'b1;
      else if (cmd_in.clear_status)
        event_summary <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Acknowledge and flush strobes; clear status gives no acknowledge
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_valid <= 1'b0;
      ack_char  <= 8'h00;
      flush     <= 1'b0;
    end else if (clk_en_in) begin
      ack_valid <= cmd_in.pre_write;
      ack_char  <= pre_ok ? `GSPE_ACK_OK : `GSPE_ACK_ERR;
      flush     <= cmd_in.clear_status;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign sre_mask_out    = service_request_enable_mask;
  assign pre_mask_out    = parallel_poll_enable_mask;
  assign status_byte_out = status_byte;
  assign ist_out         = ist;
  assign srq_out         = mss;
  assign ppm_out         = parallel_poll_line_sense_setting;
  assign poll_out.respond = ist && mode_has_line;
  assign poll_out.line   = (parallel_poll_line_sense_setting <= `GSPE_PPM_LAST_S1) ?
                           3'(parallel_poll_line_sense_setting - 5'h01) :
                           3'(parallel_poll_line_sense_setting - 5'h09);
  assign poll_out.sense  = (parallel_poll_line_sense_setting <= `GSPE_PPM_LAST_S1);
  assign ack_valid_out   = ack_valid;
  assign ack_char_out    = ack_char;
  assign flush_out       = flush;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_sre_bit6;
    @(posedge clk_in) disable iff (sys_rst_in) !sre_mask_out[6];
  endproperty
  a_sre_bit6: assert property (p_sre_bit6) else $error("SERVICE_REQUEST_ENABLE_MASK bit 6 set");

  property p_srq_esb;
    @(posedge clk_in) disable iff (sys_rst_in)
      (sre_mask_out[5] && status_byte_out[5]) |-> (srq_out && status_byte_out[6]);
  endproperty
  a_srq_esb: assert property (p_srq_esb) else $error("ESB did not raise MSS");

  property p_cls;
    @(posedge clk_in) disable iff (sys_rst_in)
      (clk_en_in && cmd_in.clear_status && !event_set_in) |=> (!status_byte_out[5] && flush_out && !ack_valid_out);
  endproperty
  a_cls: assert property (p_cls) else $error("Clear status failed");

  property p_ist;
    @(posedge clk_in) disable iff (sys_rst_in)
      ist_out == (|(status_byte_out & pre_mask_out));
  endproperty
  a_ist: assert property (p_ist) else $error("IST mismatch");

  property p_pre_store;
    @(posedge clk_in) disable iff (sys_rst_in)
      (clk_en_in && cmd_in.pre_write && !cmd_in.pre_value[16]) |=> pre_mask_out == $past(cmd_in.pre_value[15:0]);
  endproperty
  a_pre_store: assert property (p_pre_store) else $error("PRE not stored");

  property p_poll;
    @(posedge clk_in) disable iff (sys_rst_in)
      poll_out.respond |-> (ist_out && ppm_out >= 5'h01 && ppm_out <= 5'h10);
  endproperty
  a_poll: assert property (p_poll) else $error("Poll answer without cause");

  property p_ack;
    @(posedge clk_in) disable iff (sys_rst_in)
      (clk_en_in && cmd_in.pre_write) |=>
        (ack_valid_out && ack_char_out == ($past(cmd_in.pre_value[16]) ? 8'h3f : 8'h30));
  endproperty
  a_ack: assert property (p_ack) else $error("Wrong PRE acknowledge");

  property p_zero;
    @(posedge clk_in) disable iff (sys_rst_in) (pre_mask_out == 16'h0000) |-> !poll_out.respond;
  endproperty
  a_zero: assert property (p_zero) else $error("Poll answer with zero mask");

  property p_mss_only;
    @(posedge clk_in) disable iff (sys_rst_in) (pre_mask_out == 16'h0040) |-> (ist_out == status_byte_out[6]);
  endproperty
  a_mss_only: assert property (p_mss_only) else $error("Mask 64 not tied to MSS");

  // --------------------------------------------------------------------------
  // Clock enable, command storage and refusal checks
  // --------------------------------------------------------------------------
  // A low enable must freeze both masks, the mode and both strobes
  property p_freeze;
    @(posedge clk_in) disable iff (sys_rst_in)
      !clk_en_in |=> ($stable(sre_mask_out) && $stable(pre_mask_out) && $stable(ppm_out) &&
                      $stable(ack_valid_out) && $stable(flush_out));
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved while enable low");

  // Stored enable mask is the written value with bit 6 dropped
  property p_sre_store;
    @(posedge clk_in) disable iff (sys_rst_in)
      (clk_en_in && cmd_in.sre_write) |=> (sre_mask_out == ($past(cmd_in.sre_value) & 8'hbf));
  endproperty
  a_sre_store: assert property (p_sre_store) else $error("Enable mask not stored");

  // A rejected poll mask write: error character and the old mask kept
  sequence s_pre_bad;
    clk_en_in && cmd_in.pre_write && cmd_in.pre_value[16];
  endsequence

  sequence s_pre_refused;
    ack_valid_out && (ack_char_out == `GSPE_ACK_ERR) && $stable(pre_mask_out);
  endsequence

  property p_pre_err;
    @(posedge clk_in) disable iff (sys_rst_in) s_pre_bad |=> s_pre_refused;
  endproperty
  a_pre_err: assert property (p_pre_err) else $error("Bad mask write not refused");

  // The acknowledge strobe never appears without a poll mask write
  property p_ack_cause;
    @(posedge clk_in) disable iff (sys_rst_in)
      (ack_valid_out && $past(clk_en_in)) |-> $past(cmd_in.pre_write);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("Acknowledge without write");

  // The buffer flush strobe only follows a clear status command
  property p_flush_cause;
    @(posedge clk_in) disable iff (sys_rst_in)
      (flush_out && $past(clk_en_in)) |-> $past(cmd_in.clear_status);
  endproperty
  a_flush_cause: assert property (p_flush_cause) else $error("Flush without clear");

  // An event in the same cycle as a clear must survive
  property p_esb_set;
    @(posedge clk_in) disable iff (sys_rst_in)
      (clk_en_in && event_set_in) |=> status_byte_out[5];
  endproperty
  a_esb_set: assert property (p_esb_set) else $error("Event summary lost");

  // The summary bit is sticky until a clear
  property p_esb_sticky;
    @(posedge clk_in) disable iff (sys_rst_in)
      (status_byte_out[5] && !cmd_in.clear_status) |=> status_byte_out[5];
  endproperty
  a_esb_sticky: assert property (p_esb_sticky) else $error("Event summary dropped");

  // Message waiting follows the output buffer level directly
  property p_mav;
    @(posedge clk_in) disable iff (sys_rst_in) status_byte_out[4] == msg_avail_in;
  endproperty
  a_mav: assert property (p_mav) else $error("Message bit wrong");

  // --------------------------------------------------------------------------
  // Poll mode checks
  // --------------------------------------------------------------------------
  // Codes above the last legal one leave the setting untouched
  property p_ppm_refuse;
    @(posedge clk_in) disable iff (sys_rst_in)
      (clk_en_in && cmd_in.ppm_write && (cmd_in.ppm_value > 5'h11)) |=> $stable(ppm_out);
  endproperty
  a_ppm_refuse: assert property (p_ppm_refuse) else $error("Illegal mode stored");

  property p_ppm_store;
    @(posedge clk_in) disable iff (sys_rst_in)
      (clk_en_in && cmd_in.ppm_write && (cmd_in.ppm_value <= 5'h11)) |=> (ppm_out == $past(cmd_in.ppm_value));
  endproperty
  a_ppm_store: assert property (p_ppm_store) else $error("Mode not stored");

  // Sense is 1 for codes up to 8 and 0 from 9 on
  property p_sense;
    @(posedge clk_in) disable iff (sys_rst_in) poll_out.sense == (ppm_out < 5'h09);
  endproperty
  a_sense: assert property (p_sense) else $error("Poll sense wrong");

  // Both halves of the code range map onto the same eight lines
  property p_line;
    @(posedge clk_in) disable iff (sys_rst_in)
      poll_out.respond |-> (poll_out.line == 3'(ppm_out - 5'h01));
  endproperty
  a_line: assert property (p_line) else $error("Poll line wrong");

  // An enabled pair with a line-bearing code must produce an answer
  property p_poll_due;
    @(posedge clk_in) disable iff (sys_rst_in)
      (ist_out && (ppm_out >= 5'h01) && (ppm_out <= 5'h10)) |-> poll_out.respond;
  endproperty
  a_poll_due: assert property (p_poll_due) else $error("Poll answer missing");

endmodule : gspe_status_poll

`default_nettype wire

/* File: verif/gspe_ctrl_model.sv */
// Bus controller model that issues command strobes to the status block
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Controller side
// ----------------------------------------------------------------------------
module gspe_ctrl_model (
  input  wire logic             clk_in,
  output gspe_pkg::gspe_cmd_type cmd_out
);
  import gspe_pkg::*;
  initial cmd_out = '0;
  // One strobe per call; a gap cycle keeps two calls from sharing an edge
  task send(input gspe_cmd_type c);
    @(posedge clk_in);
    #1 cmd_out = c;
    @(posedge clk_in);
    #1 cmd_out = '0;
  endtask : send
endmodule : gspe_ctrl_model
`default_nettype wire

/* File: verif/tb.sv */
// Testbench for the status and poll enable block
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------------
module tb;
  import gspe_pkg::*;
  logic          clk_in, rst, en, ev, msg, ist, srq, ack_v, flush;
  logic [15:0]   oth, pmask, stat;
  logic [7:0]    emask, ack_c;
  logic [4:0]    mode;
  gspe_cmd_type  cmd, c;
  gspe_poll_type poll;
  int            fail_count, num_checks, cyc;

  gspe_ctrl_model u_ctrl (.clk_in(clk_in), .cmd_out(cmd));
  gspe_status_poll u_dut (.clk_in(clk_in), .sys_rst_in(rst), .clk_en_in(en), .cmd_in(cmd),
    .event_set_in(ev), .msg_avail_in(msg), .other_status_in(oth), .sre_mask_out(emask),
    .pre_mask_out(pmask), .status_byte_out(stat), .ist_out(ist), .srq_out(srq), .poll_out(poll),
    .ppm_out(mode), .ack_valid_out(ack_v), .ack_char_out(ack_c), .flush_out(flush));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Hang guard: the whole sequence needs well under 300 cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Kind 0 enable mask, 1 poll mask, 2 clear, other mode; returns in the answer cycle
  task wr(input int k, input logic [16:0] v);
    c = '0;
    case (k)
      0: begin c.sre_write = 1'b1; c.sre_value = v[7:0]; end
      1: begin c.pre_write = 1'b1; c.pre_value = v; end
      2: c.clear_status = 1'b1;
      default: begin c.ppm_write = 1'b1; c.ppm_value = v[4:0]; end
    endcase
    u_ctrl.send(c);
  endtask : wr

  initial begin
    rst = 1'b1;
    en = 1'b1;
    ev = 1'b0;
    msg = 1'b0;
    oth = 16'h0000;
    fail_count = 0;
    num_checks = 0;
    cyc = 0;
    repeat (5) @(posedge clk_in);
    #1 rst = 1'b0;
    chk(pmask, 16'hffff);
    chk(16'(emask), 16'h00bf);
    $display("reset values done");
    wr(0, 17'h000ff);
    chk(16'(emask), 16'h00bf);
    wr(0, 17'h00020);
    chk(16'(emask), 16'h0020);
    wr(1, 17'h00040);
    chk(16'({ack_v, ack_c}), 16'h0130);
    chk(pmask, 16'h0040);
    wr(1, 17'h1ffff);
    chk(16'({ack_v, ack_c}), 16'h013f);
    chk(pmask, 16'h0040);
    $display("mask writes done");
    wr(3, 17'h00001);
    #1 msg = 1'b1;
    #1 chk(16'({stat[4], ist}), 16'h0002);
    @(posedge clk_in) #1 ev = 1'b1;
    @(posedge clk_in) #1 ev = 1'b0;
    chk(16'(stat[6:5]), 16'h0003);
    chk(16'({srq, ist, poll.respond}), 16'h0007);
    oth = 16'hffff;
    wr(1, 17'h00000);
    chk(16'({ist, poll.respond}), 16'h0000);
    wr(1, 17'h0ffff);
    wr(2, 17'h00000);
    chk(16'({flush, ack_v, stat[5], srq}), 16'h0008);
    $display("status and clear done");
    for (int m = 0; m < 18; m++) begin
      wr(3, 17'(m));
      chk(16'(mode), 16'(m));
      chk(16'({poll.respond, poll.sense}), 16'({m > 0 && m < 17, m < 9}));
      if (m > 0 && m < 17) chk(16'(poll.line), 16'((m - 1) % 8));
    end
    $display("mode codes done");
    wr(3, 17'h00012);
    chk(16'(mode), 16'h0011);
    en = 1'b0;
    wr(0, 17'h00000);
    chk(16'({ack_v, emask}), 16'h0020);
    en = 1'b1;
    $display("refused writes done");
    wr(1, 17'h00040);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk_in);
    #1 rst = 1'b0;
    chk(pmask, 16'hffff);
    chk(16'({mode, emask}), 16'h00bf);
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
